// >>> src/hot_plug_slot_fault_control.sv
/*
  Per-slot fault latching, override, alert and limit timing for a
  dual-slot hot-plug power controller.
  Assumes analog comparators deliver sense voltage and temperature as
  synchronous digital codes, and a host reaches the status bits by ports.
*/
// Operation
// (RULE1) Trip output low whenever any slot isolation fault latches.
// (RULE2) Main-rail trip released when main enable goes low.
// (RULE3) Auxiliary trip released when standby enable goes low.
// (RULE4) Both faults latched: both enables must go low.
// (RULE5) Override turns all outputs on, bypassing most protections.
// (RULE6) Override never bypasses standby undervoltage lockout.
// (RULE7) Override releases power-good and trip outputs.
// (RULE8) Status keeps real supply conditions during override.
// (RULE9) Control bits unconditionally disable override per slot.
// (RULE10) Spare input levels shown in flags bits four and five.
// (RULE11) Address pins captured when standby supply rises.
// (RULE12) Alert asserted on fault when mask bit is zero.
// (RULE13) Alert clears after host echo-resets the fault bits.
// (RULE14) Main rail trips after limit lasts the programmed duration.
// (RULE15) Sense at or above 50 mV starts limit timer.
// (RULE16) Sense at 100 mV trips main rail at once.
// (RULE17) In overcurrent, thermal trip at 140, release at 130.
// (RULE18) Otherwise all outputs latch off at 160, release 150.
// (RULE19) Controller holds enable pulses at least 100 ns; the code adds no pulse hold, enables only pass the two-stage synchroniser.
// (RULE20) Power-on reset held 250 us after standby valid.
// (RULE21) Main on at enable rise; low turns off, clears latches.
// (RULE22) Standby enable level-sensitive; low clears aux fault.
// (RULE23) Power-good once commanded on and all outputs delivering.
// (RULE24) Registers cleared, outputs off during power-on reset.
// (RULE25) Asynchronous inputs pass a two-stage synchroniser first.
`timescale 1ns/100ps
module hot_plug_slot_fault_control
  import slot_fault_pkg::*;
#(
  parameter int POR_COUNT   = POR_CYCLES,
  parameter int LIMIT_COUNT = LIMIT_CYCLES
)(
  input  wire logic       clock_i,
  input  wire logic       rst_i,
  input  wire logic       standby_supply_i,
  input  wire logic       stby_uvlo_i,
  input  wire logic [1:0] main_uvlo_i,
  input  wire logic [1:0] main_rail_enable_i,
  input  wire logic [1:0] standby_rail_enable_i,
  input  wire logic [1:0] diag_override_n_i,
  input  wire logic [1:0] spare_input_i,
  input  wire logic [2:0] bus_addr_select_i,
  input  wire logic [7:0] sense12_mv_a_i,
  input  wire logic [7:0] sense12_mv_b_i,
  input  wire logic [7:0] sense3_mv_a_i,
  input  wire logic [7:0] sense3_mv_b_i,
  input  wire logic [1:0] aux_overcurrent_i,
  input  wire logic [1:0] out_good_i,
  input  wire logic [7:0] temp_a_i,
  input  wire logic [7:0] temp_b_i,
  input  wire logic [1:0] limit_cap_fitted_i,
  input  wire logic [15:0] limit_cap_cycles_i,
  input  wire logic [1:0] ctrl_ovr_dis_i,
  input  wire logic       alert_mask_i,
  input  wire logic [1:0] echo_clear_main_i,
  input  wire logic [1:0] echo_clear_aux_i,
  output logic      [1:0] main_on_o,
  output logic      [1:0] aux_on_o,
  output logic      [1:0] slot_trip_n_o,
  output logic      [1:0] slot_trip_n_oe_o,
  output logic      [1:0] power_good_n_o,
  output logic      [1:0] power_good_n_oe_o,
  output logic            host_alert_n_o,
  output logic            host_alert_n_oe_o,
  output logic      [7:0] slot_condition_o,
  output logic      [7:0] shared_flags_o,
  output logic      [2:0] smbus_addr_o,
  output logic            ready_o
);
  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  slot_sync_if sy ();
  input_sync u_sync (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .raw_i   ({spare_input_i, diag_override_n_i, standby_rail_enable_i,
                main_rail_enable_i}),
    .sy      (sy)
  );

  function automatic logic at_least(input logic [7:0] v, input logic [7:0] th);
    at_least = (v >= th);
  endfunction

  // ****************************************************************
  // Power-on reset sequencer
  // ****************************************************************
  por_state_t        por_r;
  por_state_t        por_nxt;
  logic [POR_W-1:0]  por_cnt_r;
  logic [POR_W-1:0]  por_cnt_nxt;
  logic              stby_q_r;
  logic              stby_q_nxt;
  logic [2:0]        addr_r;
  logic [2:0]        addr_nxt;
  logic              run;

  // (RULE20) hold reset 250 us
  always_comb begin
    por_nxt     = por_r;
    por_cnt_nxt = por_cnt_r;
    stby_q_nxt  = standby_supply_i;
    addr_nxt    = addr_r;
    // (RULE11) capture address on rise
    if (standby_supply_i && !stby_q_r) begin
      addr_nxt = bus_addr_select_i;
    end
    case (por_r)
      POR_IDLE: begin
        por_cnt_nxt = '0;
        if (standby_supply_i && !stby_uvlo_i) begin
          por_nxt = POR_WAIT;
        end
      end
      POR_WAIT: begin
        if (!standby_supply_i || stby_uvlo_i) begin
          por_nxt = POR_IDLE;
        end else if (por_cnt_r >= POR_W'(POR_COUNT - 1)) begin
          por_nxt = POR_RUN;
        end else begin
          por_cnt_nxt = por_cnt_r + 1'b1;
        end
      end
      POR_RUN: begin
        if (!standby_supply_i || stby_uvlo_i) begin
          por_nxt = POR_IDLE;
        end
      end
      default: por_nxt = POR_IDLE;
    endcase
    if (rst_i) begin
      por_nxt     = POR_IDLE;
      por_cnt_nxt = '0;
      stby_q_nxt  = 1'b0;
      addr_nxt    = ADDR_RESET;
    end
  end
  always_ff @(posedge clock_i) begin
    por_r     <= por_nxt;
    por_cnt_r <= por_cnt_nxt;
    stby_q_r  <= stby_q_nxt;
    addr_r    <= addr_nxt;
  end
  assign run = (por_r == POR_RUN);

  // ****************************************************************
  // Per-slot fault logic
  // ****************************************************************
  logic [1:0]       men_q_r;
  logic [1:0]       men_q_nxt;
  logic [1:0]       main_cmd_r;
  logic [1:0]       main_cmd_nxt;
  logic [1:0]       main_flt_r;
  logic [1:0]       main_flt_nxt;
  logic [1:0]       aux_flt_r;
  logic [1:0]       aux_flt_nxt;
  logic [1:0]       oc_hot_r;
  logic [1:0]       oc_hot_nxt;
  logic [1:0]       all_hot_r;
  logic [1:0]       all_hot_nxt;
  logic [1:0]       st_main_r;
  logic [1:0]       st_main_nxt;
  logic [1:0]       st_aux_r;
  logic [1:0]       st_aux_nxt;
  logic [LIMIT_W-1:0] lim_cnt_r [NSLOT];
  logic [LIMIT_W-1:0] lim_cnt_nxt [NSLOT];
  logic [7:0]       s12 [NSLOT];
  logic [7:0]       s3 [NSLOT];
  logic [7:0]       tj [NSLOT];
  logic [1:0]       ovr;

  assign s12[0] = sense12_mv_a_i;
  assign s12[1] = sense12_mv_b_i;
  assign s3[0]  = sense3_mv_a_i;
  assign s3[1]  = sense3_mv_b_i;
  assign tj[0]  = temp_a_i;
  assign tj[1]  = temp_b_i;
  // (RULE9) control bits defeat override
  assign ovr = ~sy.ovr_n & ~ctrl_ovr_dis_i;

  always_comb begin
    men_q_nxt    = sy.main_en;
    main_cmd_nxt = main_cmd_r;
    main_flt_nxt = main_flt_r;
    aux_flt_nxt  = aux_flt_r;
    oc_hot_nxt   = oc_hot_r;
    all_hot_nxt  = all_hot_r;
    st_main_nxt  = st_main_r;
    st_aux_nxt   = st_aux_r;
    for (int i = 0; i < NSLOT; i++) begin
      logic limit;
      logic fast;
      logic expired;
      logic [LIMIT_W-1:0] dur;
      limit   = 1'b0;
      fast    = 1'b0;
      expired = 1'b0;
      // (RULE14) cap-set or default duration
      dur = limit_cap_fitted_i[i] ? limit_cap_cycles_i : LIMIT_W'(LIMIT_COUNT);
      lim_cnt_nxt[i] = '0;
      // (RULE15) limit threshold
      limit = at_least(s12[i], SENSE_LIMIT_MV) || at_least(s3[i], SENSE_LIMIT_MV);
      // (RULE16) fast trip threshold
      fast = at_least(s12[i], SENSE_FAST_MV) || at_least(s3[i], SENSE_FAST_MV);
      if (limit && main_cmd_r[i]) begin
        expired = (lim_cnt_r[i] >= dur - 1'b1);
        lim_cnt_nxt[i] = expired ? lim_cnt_r[i] : lim_cnt_r[i] + 1'b1;
      end
      // (RULE17) overcurrent thermal hysteresis
      if (limit && at_least(tj[i], TEMP_OC_TRIP)) begin
        oc_hot_nxt[i] = 1'b1;
      end else if (!at_least(tj[i], TEMP_OC_REL + 8'h01)) begin
        oc_hot_nxt[i] = 1'b0;
      end
      // (RULE18) general thermal latch
      if (at_least(tj[i], TEMP_ALL_TRIP)) begin
        all_hot_nxt[i] = 1'b1;
      end else if (!at_least(tj[i], TEMP_ALL_REL + 8'h01)) begin
        all_hot_nxt[i] = 1'b0;
      end
      // (RULE21) rising edge switches main on
      if (sy.main_en[i] && !men_q_r[i] && !main_flt_r[i]) begin
        main_cmd_nxt[i] = 1'b1;
      end
      // (RULE8) real status regardless of override
      if (main_cmd_r[i] && (expired || fast || main_uvlo_i[i] || oc_hot_r[i]
          || all_hot_r[i])) begin
        main_flt_nxt[i] = 1'b1;
        st_main_nxt[i]  = 1'b1;
        main_cmd_nxt[i] = 1'b0;
      end else if (echo_clear_main_i[i]) begin
        st_main_nxt[i] = 1'b0;
      end
      if (sy.stby_en[i] && (aux_overcurrent_i[i] || all_hot_r[i])) begin
        aux_flt_nxt[i] = 1'b1;
        st_aux_nxt[i]  = 1'b1;
      end else if (echo_clear_aux_i[i]) begin
        st_aux_nxt[i] = 1'b0;
      end
      // (RULE2) main enable low clears main latch
      if (!sy.main_en[i]) begin
        main_cmd_nxt[i] = 1'b0;
        main_flt_nxt[i] = 1'b0;
      end
      // (RULE3) (RULE22) standby enable low clears aux latch
      if (!sy.stby_en[i]) begin
        aux_flt_nxt[i] = 1'b0;
      end
    end
    // (RULE24) clear during power-on reset
    if (rst_i || !run) begin
      men_q_nxt    = '0;
      main_cmd_nxt = '0;
      main_flt_nxt = '0;
      aux_flt_nxt  = '0;
      oc_hot_nxt   = '0;
      all_hot_nxt  = '0;
      st_main_nxt  = '0;
      st_aux_nxt   = '0;
      for (int i = 0; i < NSLOT; i++) begin
        lim_cnt_nxt[i] = '0;
      end
    end
  end
  always_ff @(posedge clock_i) begin
    men_q_r    <= men_q_nxt;
    main_cmd_r <= main_cmd_nxt;
    main_flt_r <= main_flt_nxt;
    aux_flt_r  <= aux_flt_nxt;
    oc_hot_r   <= oc_hot_nxt;
    all_hot_r  <= all_hot_nxt;
    st_main_r  <= st_main_nxt;
    st_aux_r   <= st_aux_nxt;
    lim_cnt_r  <= lim_cnt_nxt;
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  logic [1:0] main_on_nxt;
  logic [1:0] aux_on_nxt;
  logic [1:0] trip_nxt;
  logic [1:0] pg_nxt;
  logic       alert_nxt;
  logic [7:0] cond_nxt;
  logic [7:0] flags_nxt;
  logic [1:0] trip_r;
  logic [1:0] pg_r;
  logic       alert_r;

  always_comb begin
    for (int i = 0; i < NSLOT; i++) begin
      // (RULE5) override forces outputs on
      main_on_nxt[i] = ovr[i] || main_cmd_r[i];
      // (RULE6) standby lockout still blocks aux
      aux_on_nxt[i] = !stby_uvlo_i && (ovr[i] || (sy.stby_en[i] && !aux_flt_r[i]));
      // (RULE1) (RULE4) trip while any latch held
      // (RULE7) override releases the pin
      trip_nxt[i] = (main_flt_r[i] || aux_flt_r[i]) && !ovr[i];
      // (RULE23) good when all outputs deliver
      pg_nxt[i] = main_cmd_r[i] && sy.stby_en[i] && !aux_flt_r[i] && out_good_i[i]
                  && !ovr[i];
    end
    cond_nxt = {4'h0, st_aux_r, st_main_r};
    // (RULE10) spare levels in flags
    flags_nxt = REG_RESET;
    flags_nxt[FLAG_SPARE_HI:FLAG_SPARE_LO] = sy.spare;
    flags_nxt[FLAG_MASK_BIT] = alert_mask_i;
    // (RULE12) (RULE13) alert until echo cleared
    alert_nxt = !alert_mask_i && ((|st_main_r) || (|st_aux_r));
    if (rst_i || !run) begin
      main_on_nxt = '0;
      aux_on_nxt  = '0;
      trip_nxt    = '0;
      pg_nxt      = '0;
      alert_nxt   = 1'b0;
      cond_nxt    = REG_RESET;
      flags_nxt   = REG_RESET;
    end
  end
  always_ff @(posedge clock_i) begin
    main_on_o        <= main_on_nxt;
    aux_on_o         <= aux_on_nxt;
    trip_r           <= trip_nxt;
    pg_r             <= pg_nxt;
    alert_r          <= alert_nxt;
    slot_condition_o <= cond_nxt;
    shared_flags_o   <= flags_nxt;
  end

  // Open-drain pins: output level is always low, enable pulls it
  assign slot_trip_n_o     = 2'h0;
  assign slot_trip_n_oe_o  = trip_r;
  assign power_good_n_o    = 2'h0;
  assign power_good_n_oe_o = pg_r;
  assign host_alert_n_o    = 1'b0;
  assign host_alert_n_oe_o = alert_r;
  assign smbus_addr_o      = addr_r;
  assign ready_o           = run;
endmodule

// >>> src/slot_fault_pkg.sv
/*
  Shared constants and types for the dual-slot fault control block.
  Assumes a single 50 MHz clock and synchronous active-high reset.
*/
package slot_fault_pkg;
  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_MHZ         = 50;
  localparam int POR_TIME_US     = 250;
  localparam int POR_CYCLES      = POR_TIME_US * CLK_MHZ;
  localparam int LIMIT_TIME_US   = 10;
  localparam int LIMIT_CYCLES    = LIMIT_TIME_US * CLK_MHZ;
  localparam int LIMIT_W         = 16;
  localparam int POR_W           = 16;
  // ****************************************************************
  // Thresholds (sense in mV, temperature in degrees C)
  // ****************************************************************
  localparam logic [7:0] SENSE_LIMIT_MV = 8'h32;
  localparam logic [7:0] SENSE_FAST_MV  = 8'h64;
  localparam logic [7:0] TEMP_OC_TRIP   = 8'h8C;
  localparam logic [7:0] TEMP_OC_REL    = 8'h82;
  localparam logic [7:0] TEMP_ALL_TRIP  = 8'hA0;
  localparam logic [7:0] TEMP_ALL_REL   = 8'h96;
  // ****************************************************************
  // Register field positions
  // ****************************************************************
  localparam int CTRL_OVR_DIS_BIT = 2;
  localparam int FLAG_MASK_BIT    = 3;
  localparam int FLAG_SPARE_LO    = 4;
  localparam int FLAG_SPARE_HI    = 5;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [2:0] ADDR_RESET = 3'h7;
  // Override and spare bits rest at their idle-high level
  localparam logic [7:0] SYNC_RESET = 8'hF0;
  localparam int NSLOT = 2;
  typedef enum logic [2:0] {
    POR_WAIT = 3'b001,
    POR_RUN  = 3'b010,
    POR_IDLE = 3'b100
  } por_state_t;
endpackage

// >>> src/slot_sync_if.sv
/*
  Bundle of synchronised per-slot inputs passed from the synchroniser
  to the fault controller.
  Assumes both ends share clock_i.
*/
`timescale 1ns/100ps
interface slot_sync_if;
  logic [1:0] main_en;
  logic [1:0] stby_en;
  logic [1:0] ovr_n;
  logic [1:0] spare;
  modport src (output main_en, output stby_en, output ovr_n, output spare);
  modport dst (input main_en, input stby_en, input ovr_n, input spare);
endinterface

// >>> src/input_sync.sv
/*
  Two-stage synchronisers for the enable, override and spare inputs.
  Assumes clock_i and synchronous reset rst_i.
*/
`timescale 1ns/100ps
module input_sync
  import slot_fault_pkg::*;
(
  input  wire logic       clock_i,
  input  wire logic       rst_i,
  input  wire logic [7:0] raw_i,
  slot_sync_if.src        sy
);
  logic [7:0] meta_r;
  logic [7:0] meta_nxt;
  logic [7:0] sync_r;
  logic [7:0] sync_nxt;
  // (RULE25) two-stage sync
  always_comb begin
    meta_nxt = rst_i ? SYNC_RESET : raw_i;
    sync_nxt = rst_i ? SYNC_RESET : meta_r;
  end
  always_ff @(posedge clock_i) begin
    meta_r <= meta_nxt;
    sync_r <= sync_nxt;
  end
  assign sy.main_en = sync_r[1:0];
  assign sy.stby_en = sync_r[3:2];
  assign sy.ovr_n   = sync_r[5:4];
  assign sy.spare   = sync_r[7:6];
endmodule

// >>> sim/slot_rail_model.sv
/*
  Behavioural model of slot A's rails, the far side of the fault block.
  Assumes the block's registered rail-on outputs and one shared clock.
*/
`timescale 1ns/100ps
module slot_rail_model (
  input  wire logic       clock_i,
  input  wire logic [1:0] main_on_i,
  input  wire logic [1:0] aux_on_i,
  input  wire logic [7:0] load_mv_i,
  output logic      [1:0] out_good_o,
  output logic      [7:0] sense12_a_o,
  output logic      [7:0] sense3_a_o
);
  initial out_good_o = 2'h0;
  // Rails need a cycle to climb above the good level
  always @(posedge clock_i) begin
    out_good_o <= main_on_i & aux_on_i;
  end
  // Load current flows only while the switch is closed
  assign sense12_a_o = main_on_i[0] ? load_mv_i : 8'h00;
  assign sense3_a_o  = 8'h00;
endmodule

// >>> sim/slot_fault_monitor.sv
/*
  Concurrent checks on slot A of the fault block, bound to its top ports.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/100ps
module slot_fault_monitor
  import slot_fault_pkg::*;
(
  input wire logic       clock_i,
  input wire logic       rst_i,
  input wire logic       standby_supply_i,
  input wire logic       stby_uvlo_i,
  input wire logic [1:0] main_rail_enable_i,
  input wire logic [1:0] standby_rail_enable_i,
  input wire logic [1:0] diag_override_n_i,
  input wire logic [1:0] ctrl_ovr_dis_i,
  input wire logic [1:0] spare_input_i,
  input wire logic [2:0] bus_addr_select_i,
  input wire logic [7:0] sense12_mv_a_i,
  input wire logic [1:0] aux_overcurrent_i,
  input wire logic [7:0] temp_a_i,
  input wire logic       alert_mask_i,
  input wire logic [1:0] main_on_o,
  input wire logic [1:0] aux_on_o,
  input wire logic [1:0] slot_trip_n_oe_o,
  input wire logic [1:0] power_good_n_oe_o,
  input wire logic       host_alert_n_oe_o,
  input wire logic [7:0] slot_condition_o,
  input wire logic [7:0] shared_flags_o,
  input wire logic [2:0] smbus_addr_o,
  input wire logic       ready_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  sequence s_ovr_held;
    (ready_o && !diag_override_n_i[0] && !ctrl_ovr_dis_i[0]) [*5];
  endsequence
  // Causes quiet too, so a latch cannot be re-armed meanwhile
  sequence s_both_low;
    (!main_rail_enable_i[0] && !standby_rail_enable_i[0] && !aux_overcurrent_i[0]
      && temp_a_i <= TEMP_ALL_REL) [*5];
  endsequence
  property p_fast_trip;
    ready_o && main_on_o[0] && diag_override_n_i[0] && $past(diag_override_n_i[0], 3)
      && sense12_mv_a_i >= SENSE_FAST_MV |-> ##[1:2] (slot_trip_n_oe_o[0] && !main_on_o[0]);
  endproperty
  a_fast_trip: assert property (p_fast_trip) else $error("fast trip missed");
  property p_trip_release;
    s_both_low |-> !slot_trip_n_oe_o[0];
  endproperty
  a_trip_release: assert property (p_trip_release) else $error("trip held");
  property p_trip_cause;
    $fell(slot_trip_n_oe_o[0]) && $past(diag_override_n_i[0], 3)
      |-> !$past(main_rail_enable_i[0], 3) || !$past(standby_rail_enable_i[0], 3);
  endproperty
  a_trip_cause: assert property (p_trip_cause) else $error("trip freed early");
  property p_ovr;
    s_ovr_held |-> main_on_o[0] && (aux_on_o[0] || stby_uvlo_i)
      && !slot_trip_n_oe_o[0] && !power_good_n_oe_o[0];
  endproperty
  a_ovr: assert property (p_ovr) else $error("override outputs wrong");
  property p_ovr_dis;
    (ready_o && ctrl_ovr_dis_i[0] && !main_rail_enable_i[0]) [*5] |-> !main_on_o[0];
  endproperty
  a_ovr_dis: assert property (p_ovr_dis) else $error("override not disabled");
  property p_aux_lock;
    stby_uvlo_i [*3] |-> aux_on_o == 2'h0;
  endproperty
  a_aux_lock: assert property (p_aux_lock) else $error("aux on under lockout");
  property p_flags;
    (ready_o && $stable(spare_input_i) && $stable(alert_mask_i)) [*4]
      |-> shared_flags_o == {2'h0, spare_input_i, alert_mask_i, 3'h0};
  endproperty
  a_flags: assert property (p_flags) else $error("flags wrong");
  property p_alert_on;
    (ready_o && !alert_mask_i && slot_condition_o[3:0] != 4'h0) [*3] |-> host_alert_n_oe_o;
  endproperty
  a_alert_on: assert property (p_alert_on) else $error("alert missing");
  property p_alert_off;
    (alert_mask_i || slot_condition_o == 8'h00) [*3] |-> !host_alert_n_oe_o;
  endproperty
  a_alert_off: assert property (p_alert_off) else $error("alert stuck");
  property p_addr;
    $rose(standby_supply_i) |-> ##[1:4] smbus_addr_o == bus_addr_select_i;
  endproperty
  a_addr: assert property (p_addr) else $error("address not captured");
  property p_por;
    (!ready_o) [*2] |-> main_on_o == 2'h0 && aux_on_o == 2'h0 && slot_trip_n_oe_o == 2'h0;
  endproperty
  a_por: assert property (p_por) else $error("output on during reset");
  property p_main_cause;
    $rose(main_on_o[0]) && $past(diag_override_n_i[0], 3) |-> $past(main_rail_enable_i[0], 3);
  endproperty
  a_main_cause: assert property (p_main_cause) else $error("main on uncommanded");
endmodule

bind hot_plug_slot_fault_control slot_fault_monitor u_slot_fault_monitor (
  .clock_i, .rst_i, .standby_supply_i, .stby_uvlo_i, .main_rail_enable_i,
  .standby_rail_enable_i, .diag_override_n_i, .ctrl_ovr_dis_i, .spare_input_i,
  .bus_addr_select_i, .sense12_mv_a_i, .aux_overcurrent_i, .temp_a_i, .alert_mask_i,
  .main_on_o, .aux_on_o, .slot_trip_n_oe_o, .power_good_n_oe_o, .host_alert_n_oe_o,
  .slot_condition_o, .shared_flags_o, .smbus_addr_o, .ready_o
);

// >>> sim/hot_plug_slot_fault_control_tb.sv
/*
  Directed testbench for the slot fault block, slot A with a rail model.
  Assumes shortened power-on and limit counts set below.
*/
`timescale 1ns/100ps
module hot_plug_slot_fault_control_tb;
  import slot_fault_pkg::*;
  localparam int POR_N = 20;
  localparam int LIM_N = 10;
  logic       clock_i, rst_i, supply, stby_uvlo, mask, alert_n, alert_oe, ready;
  logic [1:0] main_uvlo, main_en, stby_en, ovr_n, spare, aux_oc, ovr_dis, clr_m, clr_a;
  logic [1:0] good, main_on, aux_on, trip_n, trip_oe, pg_n, pg_oe;
  logic [2:0] addr_sel, addr;
  logic [7:0] load, s12, s3, temp, cond, flags;
  int         errors, total_checks;
  hot_plug_slot_fault_control #(.POR_COUNT(POR_N), .LIMIT_COUNT(LIM_N))
    u_hot_plug_slot_fault_control (
    .clock_i(clock_i), .rst_i(rst_i), .standby_supply_i(supply), .stby_uvlo_i(stby_uvlo),
    .main_uvlo_i(main_uvlo), .main_rail_enable_i(main_en), .standby_rail_enable_i(stby_en),
    .diag_override_n_i(ovr_n), .spare_input_i(spare), .bus_addr_select_i(addr_sel),
    .sense12_mv_a_i(s12), .sense12_mv_b_i(8'h00), .sense3_mv_a_i(s3), .sense3_mv_b_i(8'h00),
    .aux_overcurrent_i(aux_oc), .out_good_i(good), .temp_a_i(temp), .temp_b_i(8'h19),
    .limit_cap_fitted_i(2'h0), .limit_cap_cycles_i(16'h0000), .ctrl_ovr_dis_i(ovr_dis),
    .alert_mask_i(mask), .echo_clear_main_i(clr_m), .echo_clear_aux_i(clr_a),
    .main_on_o(main_on), .aux_on_o(aux_on), .slot_trip_n_o(trip_n), .slot_trip_n_oe_o(trip_oe),
    .power_good_n_o(pg_n), .power_good_n_oe_o(pg_oe), .host_alert_n_o(alert_n),
    .host_alert_n_oe_o(alert_oe), .slot_condition_o(cond), .shared_flags_o(flags),
    .smbus_addr_o(addr), .ready_o(ready));
  slot_rail_model u_slot_rail_model (.clock_i(clock_i), .main_on_i(main_on), .aux_on_i(aux_on),
    .load_mv_i(load), .out_good_o(good), .sense12_a_o(s12), .sense3_a_o(s3));
  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    #2;
  endtask
  task automatic chk(input logic [7:0] act, input logic [7:0] exp);
    total_checks++;
    if (act !== exp) begin
      errors++;
      $display("ERROR t=%0t act=%h exp=%h", $time, act, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks=%0d errors=%0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Bounded wait for the end of power-on reset
  task automatic wait_ready(input int lim, output int n);
    n = 0;
    while (ready !== 1'b1 && n < lim) begin
      tick(1);
      n++;
    end
    if (n == lim) begin
      errors++;
      report_and_stop();
    end
  endtask
  // Enables low first, then echo both status groups
  task automatic t_clear;
    load = 8'h00;
    main_en = 2'h0;
    stby_en = 2'h0;
    aux_oc = 2'h0;
    temp = 8'h19;
    tick(6);
    clr_m = 2'h1;
    clr_a = 2'h1;
    tick(1);
    clr_m = 2'h0;
    clr_a = 2'h0;
    tick(3);
  endtask
  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_por;
    int n;
    addr_sel = 3'h5;
    tick(2);
    chk({5'h00, addr}, 8'h07);
    supply = 1'b1;
    tick(POR_N - 2);
    chk({7'h00, ready}, 8'h00);
    chk({main_on, aux_on, trip_oe, pg_oe}, 8'h00);
    wait_ready(10, n);
    chk(8'(n), 8'h03);
    chk({5'h00, addr}, 8'h05);
    $display("t_por done");
  endtask
  task automatic t_fast;
    stby_en = 2'h1;
    main_en = 2'h1;
    tick(5);
    chk({6'h00, main_on[0], aux_on[0]}, 8'h03);
    tick(3);
    chk({6'h00, pg_oe[0], trip_oe[0]}, 8'h02);
    load = 8'h64;
    tick(3);
    chk({4'h0, trip_oe[0], main_on[0], cond[0], alert_oe}, 8'h0B);
    main_en = 2'h0;
    tick(2);
    chk({7'h00, trip_oe[0]}, 8'h01);
    tick(3);
    chk({6'h00, trip_oe[0], alert_oe}, 8'h01);
    t_clear();
    chk({cond[0], alert_oe}, 8'h00);
    $display("t_fast done");
  endtask
  task automatic t_limit;
    mask = 1'b1;
    main_en = 2'h1;
    stby_en = 2'h1;
    tick(6);
    load = 8'h31;
    tick(LIM_N + 4);
    chk({7'h00, main_on[0]}, 8'h01);
    load = 8'h32;
    tick(LIM_N - 1);
    chk({7'h00, main_on[0]}, 8'h01);
    tick(5);
    chk({4'h0, trip_oe[0], main_on[0], alert_oe, flags[3]}, 8'h09);
    t_clear();
    main_en = 2'h1;
    tick(6);
    temp = 8'h8C;
    load = 8'h32;
    tick(4);
    chk({6'h00, trip_oe[0], main_on[0]}, 8'h02);
    t_clear();
    mask = 1'b0;
    $display("t_limit done");
  endtask
  task automatic t_both;
    main_en = 2'h1;
    stby_en = 2'h1;
    tick(6);
    load = 8'h64;
    aux_oc = 2'h1;
    tick(4);
    chk({cond[3:0], 3'h0, trip_oe[0]}, 8'h51);
    main_en = 2'h0;
    load = 8'h00;
    tick(6);
    chk({7'h00, trip_oe[0]}, 8'h01);
    aux_oc = 2'h0;
    stby_en = 2'h0;
    tick(6);
    chk({7'h00, trip_oe[0]}, 8'h00);
    t_clear();
    $display("t_both done");
  endtask
  task automatic t_ovr;
    int n;
    main_uvlo = 2'h1;
    ovr_n = 2'h2;
    tick(5);
    chk({4'h0, main_on[0], aux_on[0], trip_oe[0], pg_oe[0]}, 8'h0C);
    stby_uvlo = 1'b1;
    tick(3);
    chk({5'h00, main_on[0], aux_on[0], ready}, 8'h00);
    stby_uvlo = 1'b0;
    wait_ready(POR_N + 5, n);
    chk(8'(n), 8'(POR_N + 1));
    ovr_dis = 2'h1;
    tick(5);
    chk({6'h00, main_on[0], aux_on[0]}, 8'h00);
    ovr_n = 2'h3;
    ovr_dis = 2'h0;
    main_uvlo = 2'h0;
    tick(4);
    $display("t_ovr done");
  endtask
  task automatic t_misc;
    spare = 2'h2;
    tick(5);
    chk(flags, 8'h20);
    spare = 2'h1;
    tick(5);
    chk(flags, 8'h10);
    stby_en = 2'h1;
    tick(5);
    temp = 8'hA0;
    tick(4);
    chk({6'h00, aux_on[0], trip_oe[0]}, 8'h01);
    chk({3'h0, trip_n, pg_n, alert_n}, 8'h00);
    t_clear();
    $display("t_misc done");
  endtask
  // ************************************************************
  // Clock and main sequence
  // ************************************************************
  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end
  initial begin
    {rst_i, supply, stby_uvlo, mask} = 4'h8;
    {main_uvlo, main_en, stby_en, spare, aux_oc, ovr_dis, clr_m, clr_a} = 16'h0000;
    ovr_n = 2'h3;
    addr_sel = 3'h7;
    load = 8'h00;
    temp = 8'h19;
    errors = 0;
    total_checks = 0;
    tick(3);
    rst_i = 1'b0;
    t_por();
    t_fast();
    t_limit();
    t_both();
    t_ovr();
    t_misc();
    report_and_stop();
  end
endmodule
